// File: rtl/bbx_core.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Opcode 11010 is jump, eleven-bit signed offset
// - Jump target is address plus 2 plus 2n
// - Jump takes two cycles, second is flush
// - Opcode 1000 is bit set with fields
// - Bit set: read, set bit, write back
// - Access bit 0 selects the access bank
// - Access bit 1 uses bank pointer register
// - Extended set, a=0, f<=95: indexed literal offset
module bbx_core
   import bbx_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // Instruction fetch
   input wire logic [15:0] instr_word,
   input wire logic next_is_long,
   // Configuration
   input wire logic ext_set_en,
   input wire logic [3:0] bank_pointer_reg,
   input wire logic [11:0] index_base,
   // Data memory
   input wire logic [7:0] mem_rdata,
   output logic [11:0] mem_addr,
   output logic mem_rd,
   output logic mem_wr,
   output logic [7:0] mem_wdata,
   // Sequencing
   output logic [20:0] pc,
   output logic [1:0] qphase,
   output logic instr_done,
   output logic flushing,
   output logic skip_taken
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   // Everything the sequencer remembers between edges
   typedef struct packed
   {
      bbx_state_e state;
      logic [1:0] q;
      logic [20:0] pc;
      logic [15:0] ir;
      logic [7:0] data;
      logic [11:0] addr;
      logic rd;
      logic wr;
      logic [7:0] wdata;
      logic skip;
   } bbx_state_s;

   bbx_state_s st_reg;
   bbx_state_s st_next;
   bbx_if ap ();

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   logic is_jump;
   logic is_set;
   logic is_tsz;
   logic is_tso;
   logic [2:0] bit_sel;
   logic [20:0] jump_ofs;
   logic bit_val;
   logic [15:0] cur_ir;
   logic bit_op;
   logic skip_hit;

   // Latch opcode in Q1, hold it for the rest of the cycle
   assign cur_ir = (st_reg.q == BBX_Q1) ? instr_word : st_reg.ir;
   assign is_jump = cur_ir[15:11] == BBX_JUMP_CODE;
   assign is_set = cur_ir[15:12] == BBX_SET_CODE;
   assign is_tsz = cur_ir[15:12] == BBX_TSZ_CODE;
   assign is_tso = cur_ir[15:12] == BBX_TSO_CODE;
   assign bit_op = is_set || is_tsz || is_tso;
   // Bit position field
   assign bit_sel = cur_ir[11:BBX_BIT_LSB];
   // Sign-extend and double the offset
   assign jump_ofs = {{9{cur_ir[BBX_OFS_MSB]}}, cur_ir[BBX_OFS_MSB:0], 1'b0};
   // Tested bit of the operand captured in Q2
   assign bit_val = st_reg.data[bit_sel];
   // Skip decision: clear for one opcode, set for the other
   assign skip_hit = (is_tsz && !bit_val) || (is_tso && bit_val);

   // ----------------------------------------
   // Operand address
   // ----------------------------------------
   // Operand address resolution
   assign ap.file_addr = cur_ir[7:0];
   assign ap.access_sel = cur_ir[BBX_ACC_POS];
   assign ap.bank = bank_pointer_reg;
   assign ap.ext_en = ext_set_en;
   assign ap.idx_base = index_base;

   bbx_addr_res u_res
   (
      .ap(ap)
   );

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_comb
   begin
      st_next = st_reg;
      st_next.rd = 1'b0;
      st_next.wr = 1'b0;
      st_next.skip = 1'b0;
      st_next.q = st_reg.q + 2'h1;
      case (st_reg.state)
         BBX_EXEC:
         begin
            case (st_reg.q)
               BBX_Q1:
               begin
                  st_next.ir = instr_word;
                  if (bit_op)
                  begin
                     // Read operand in Q2
                     st_next.addr = ap.data_addr;
                     st_next.rd = 1'b1;
                  end
               end
               BBX_Q2:
               begin
                  // Capture the operand at the end of Q2
                  if (st_reg.rd)
                  begin
                     st_next.data = mem_rdata;
                  end
               end
               BBX_Q3:
               begin
                  if (is_set)
                  begin
                     // Set only the chosen bit, write in Q4
                     st_next.wdata = st_reg.data | (8'h01 << bit_sel);
                     st_next.wr = 1'b1;
                  end
               end
               default:
               begin
                  // Q4: step past this word unless redirected
                  st_next.pc = st_reg.pc + BBX_PC_STEP;
                  if (is_jump)
                  begin
                     // PC still points at this word, so step past it before adding the offset
                     st_next.pc = st_reg.pc + BBX_PC_STEP + jump_ofs;
                     st_next.state = BBX_FLUSH1;
                  end
                  else if (skip_hit)
                  begin
                     // Drop the word already fetched
                     st_next.skip = 1'b1;
                     st_next.state = next_is_long ? BBX_FLUSH2 : BBX_FLUSH1;
                  end
               end
            endcase
         end
         BBX_FLUSH2:
         begin
            // Discard first word of skipped long instruction, then FLUSH1 drops the second
            if (st_reg.q == BBX_Q4)
            begin
               st_next.pc = st_reg.pc + BBX_PC_STEP;
               st_next.state = BBX_FLUSH1;
            end
         end
         default:
         begin
            // No-operation cycle while the pipeline refills
            if (st_reg.q == BBX_Q4)
            begin
               // A jump already holds its target
               if (st_reg.ir[15:11] != BBX_JUMP_CODE)
               begin
                  st_next.pc = st_reg.pc + BBX_PC_STEP;
               end
               st_next.state = BBX_EXEC;
            end
         end
      endcase
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   // Synchronous reset; clock enable freezes every field
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         st_reg <= '{state: BBX_EXEC, q: BBX_Q_RST, pc: BBX_PC_RST, default: '0};
      end
      else if (clk_en)
      begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Registered data and strobes, status from state
   assign mem_addr = st_reg.addr;
   assign mem_rd = st_reg.rd;
   assign mem_wr = st_reg.wr;
   assign mem_wdata = st_reg.wdata;
   assign pc = st_reg.pc;
   assign qphase = st_reg.q;
   assign flushing = st_reg.state != BBX_EXEC;
   assign skip_taken = st_reg.skip;
   assign instr_done = (st_reg.q == BBX_Q4) && clk_en; // Last quarter of a cycle
endmodule : bbx_core

// File: rtl/bbx_pkg.sv
package bbx_pkg;
   // ----------------------------------------
   // Opcode fields
   // ----------------------------------------
   localparam logic [4:0] BBX_JUMP_CODE = 5'h1a;
   localparam logic [3:0] BBX_SET_CODE = 4'h8;
   localparam logic [3:0] BBX_TSZ_CODE = 4'hb;
   localparam logic [3:0] BBX_TSO_CODE = 4'ha;
   localparam int BBX_OFS_MSB = 10;
   localparam int BBX_BIT_LSB = 9;
   localparam int BBX_ACC_POS = 8;
   localparam logic [7:0] BBX_ILO_LIMIT = 8'h5f;
   localparam logic [7:0] BBX_ACC_SPLIT = 8'h60;
   localparam logic [3:0] BBX_SFR_BANK = 4'hf;
   localparam logic [20:0] BBX_PC_STEP = 21'h000002;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [20:0] BBX_PC_RST = 21'h000000;
   localparam logic [1:0] BBX_Q_RST = 2'h0;
   // ----------------------------------------
   // Phases and states
   // ----------------------------------------
   localparam logic [1:0] BBX_Q1 = 2'h0;
   localparam logic [1:0] BBX_Q2 = 2'h1;
   localparam logic [1:0] BBX_Q3 = 2'h2;
   localparam logic [1:0] BBX_Q4 = 2'h3;
   typedef enum logic [2:0]
   {
      BBX_EXEC = 3'b001,
      BBX_FLUSH1 = 3'b010,
      BBX_FLUSH2 = 3'b100
   } bbx_state_e;
endpackage : bbx_pkg

// File: rtl/bbx_if.sv
`timescale 1ns/1ns
// Operand address path between decoder and address resolver
interface bbx_if;
   logic [7:0] file_addr;
   logic access_sel;
   logic [3:0] bank;
   logic ext_en;
   logic [11:0] idx_base;
   logic [11:0] data_addr;
   modport core (output file_addr, access_sel, bank, ext_en, idx_base, input data_addr);
   modport res (input file_addr, access_sel, bank, ext_en, idx_base, output data_addr);
endinterface : bbx_if

// File: rtl/bbx_addr_res.sv
`timescale 1ns/1ns
module bbx_addr_res
   import bbx_pkg::*;
(
   // Address path
   bbx_if.res ap
);
   // Banked, access bank or indexed literal offset
   always_comb
   begin
      if (!ap.access_sel && ap.ext_en && ap.file_addr <= BBX_ILO_LIMIT)
      begin
         ap.data_addr = ap.idx_base + {4'h0, ap.file_addr};
      end
      else if (!ap.access_sel)
      begin
         // Below 60h is bank 0, from 60h up the special bank
         ap.data_addr = (ap.file_addr < BBX_ACC_SPLIT) ? {4'h0, ap.file_addr}
                                                       : {BBX_SFR_BANK, ap.file_addr};
      end
      else
      begin
         ap.data_addr = {ap.bank, ap.file_addr};
      end
   end
endmodule : bbx_addr_res

// File: verif/bbx_monitor.sv
`timescale 1ns/1ns
// ----------------------------------------
// Port checker for the decode core
// ----------------------------------------
module bbx_monitor
   import bbx_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // Observed ports
   input wire logic [7:0] mem_rdata,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic [7:0] mem_wdata,
   input wire logic [20:0] pc,
   input wire logic [1:0] qphase,
   input wire logic flushing,
   input wire logic skip_taken
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Strobes sit in their quarters
   property p_rd_q2; mem_rd |-> qphase == BBX_Q2 && !flushing; endproperty
   a_rd_q2: assert property (p_rd_q2) else $error("read strobe outside Q2");
   property p_wr_q4; mem_wr |-> qphase == BBX_Q4 && $past(mem_rd, 2); endproperty
   a_wr_q4: assert property (p_wr_q4) else $error("write not after read");
   property p_q_step; clk_en && !sys_rst |=> qphase == $past(qphase) + 2'h1; endproperty
   a_q_step: assert property (p_q_step) else $error("quarter count broken");
   // Write back keeps read bits, adds at most one
   property p_set_bit;
      mem_wr |-> (mem_wdata & $past(mem_rdata, 2)) == $past(mem_rdata, 2)
         && $countones(mem_wdata ^ $past(mem_rdata, 2)) <= 1;
   endproperty
   a_set_bit: assert property (p_set_bit) else $error("write data wrong");
   property p_flush_quiet; flushing |-> !mem_rd && !mem_wr; endproperty
   a_flush_quiet: assert property (p_flush_quiet) else $error("access in flush");
   property p_flush_len; $rose(flushing) |-> qphase == BBX_Q1 ##0 flushing [*4]; endproperty
   a_flush_len: assert property (p_flush_len) else $error("flush too short");
   property p_skip_q1; skip_taken |-> qphase == BBX_Q1 && flushing; endproperty
   a_skip_q1: assert property (p_skip_q1) else $error("skip pulse misplaced");
   property p_pc_q1; $changed(pc) |-> qphase == BBX_Q1; endproperty
   a_pc_q1: assert property (p_pc_q1) else $error("pc moved mid cycle");
endmodule : bbx_monitor

bind bbx_core bbx_monitor u_bbx_monitor (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
   .mem_rdata(mem_rdata), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
   .pc(pc), .qphase(qphase), .flushing(flushing), .skip_taken(skip_taken));

// File: verif/tb_top.sv
`timescale 1ns/1ns
// ----------------------------------------
// Bench for the decode core
// ----------------------------------------
module tb_top
   import bbx_pkg::*;
;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic clk_en = 1'b1;
   logic [15:0] instr_word = 16'h0000;
   logic next_is_long = 1'b0;
   logic ext_set_en = 1'b0;
   logic [3:0] bank_pointer_reg = 4'h3;
   logic [11:0] index_base = 12'h120;
   logic [7:0] mem [4096];
   logic [7:0] mem_rdata;
   logic [11:0] mem_addr;
   logic [7:0] mem_wdata;
   logic [20:0] pc;
   logic [20:0] pc_exp = 21'h000000;
   logic [1:0] qphase;
   logic mem_rd, mem_wr, instr_done, flushing, skip_taken, ext_nx, long_nx;
   int error_cnt = 0;
   int tests_run = 0;
   bbx_core u_bbx_core (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .instr_word(instr_word),
      .next_is_long(next_is_long), .ext_set_en(ext_set_en), .bank_pointer_reg(bank_pointer_reg),
      .index_base(index_base), .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_rd(mem_rd),
      .mem_wr(mem_wr), .mem_wdata(mem_wdata), .pc(pc), .qphase(qphase),
      .instr_done(instr_done), .flushing(flushing), .skip_taken(skip_taken));
   // Clock and data memory
   always #50 clk = ~clk;
   assign mem_rdata = mem[mem_addr];
   always @(posedge clk)
      if (mem_wr === 1'b1)
         mem[mem_addr] <= mem_wdata;
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e)
      begin
         error_cnt++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic results;
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : results
   // One instruction cycle, entered and left in Q4
   task automatic issue(input logic [15:0] w, input logic fl, input logic sk, input logic rd);
      @(posedge clk);
      instr_word <= w;
      ext_set_en <= ext_nx;
      next_is_long <= long_nx;
      @(negedge clk);
      chk("pc", pc_exp, pc);
      chk("flushing", fl, flushing);
      chk("skip", sk, skip_taken);
      @(negedge clk);
      chk("read", rd, mem_rd);
      repeat (2) @(negedge clk);
      chk("done", 1'b1, instr_done);
      chk("quarter", BBX_Q4, qphase);
   endtask : issue
   task automatic t_set;
      logic [7:0] f [6] = '{8'h55, 8'h5f, 8'h60, 8'h5f, 8'h60, 8'hff};
      logic [11:0] ad [6] = '{12'h355, 12'h05f, 12'hf60, 12'h17f, 12'hf60, 12'h3ff};
      logic [5:0] acc = 6'b100001;
      logic [7:0] old;
      for (int i = 0; i < 6; i++)
      begin
         old = mem[ad[i]];
         ext_nx = i > 2;
         issue({BBX_SET_CODE, 3'(i * 3), acc[i], f[i]}, 1'b0, 1'b0, 1'b1);
         chk("addr", 32'(ad[i]), 32'(mem_addr));
         chk("wdata", 32'(8'(old | (8'h01 << 3'(i * 3)))), 32'(mem_wdata));
         chk("write", 1, mem_wr);
         pc_exp = pc_exp + BBX_PC_STEP;
      end
      ext_nx = 1'b0;
      $display("t_set done");
   endtask : t_set
   // Clock enable low in Q1 of a jump must freeze the core
   task automatic t_hold;
      @(posedge clk);
      instr_word <= {BBX_JUMP_CODE, 11'h004};
      clk_en <= 1'b0;
      repeat (3) @(negedge clk);
      chk("hold quarter", BBX_Q1, qphase);
      chk("hold pc", pc_exp, pc);
      chk("hold done", 1'b0, instr_done);
      @(posedge clk);
      clk_en <= 1'b1;
      repeat (4) @(negedge clk);
      chk("hold quarter", BBX_Q4, qphase);
      chk("hold pc", pc_exp, pc);
      // Two plus twice the offset of four
      pc_exp = pc_exp + 21'h00000a;
      issue(16'h0000, 1'b1, 1'b0, 1'b0);
      $display("t_hold done");
   endtask : t_hold
   task automatic t_jump;
      int n [3] = '{-1024, 1023, 5};
      foreach (n[i])
      begin
         issue({BBX_JUMP_CODE, 11'(n[i])}, 1'b0, 1'b0, 1'b0);
         pc_exp = pc_exp + 21'(2 + 2 * n[i]);
         issue(16'h8fff, 1'b1, 1'b0, 1'b0);
      end
      $display("t_jump done");
   endtask : t_jump
   task automatic t_skip;
      logic [2:0] b;
      logic sk;
      for (int k = 0; k < 8; k++)
      begin
         b = 3'(k);
         mem[12'h3aa] = k[1] ? 8'h01 << b : ~(8'h01 << b);
         sk = k[0] ? k[1] : !k[1];
         long_nx = k[2];
         issue({k[0] ? BBX_TSO_CODE : BBX_TSZ_CODE, b, 1'b1, 8'haa}, 1'b0, 1'b0, 1'b1);
         chk("no write", 0, mem_wr);
         pc_exp = pc_exp + BBX_PC_STEP;
         if (sk)
         begin
            issue(16'h0000, 1'b1, 1'b1, 1'b0);
            pc_exp = pc_exp + BBX_PC_STEP;
            if (k[2])
            begin
               issue(16'h0000, 1'b1, 1'b0, 1'b0);
               pc_exp = pc_exp + BBX_PC_STEP;
            end
         end
      end
      $display("t_skip done");
   endtask : t_skip
   // Hang guard
   initial
   begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      results();
   end
   // Main sequence
   initial
   begin
      foreach (mem[i]) mem[i] = 8'(i * 7);
      ext_nx = 1'b0;
      long_nx = 1'b0;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (4) @(negedge clk);
      pc_exp = BBX_PC_STEP;
      t_set();
      t_hold();
      t_jump();
      t_skip();
      issue(16'h0000, 1'b0, 1'b0, 1'b0);
      results();
   end
endmodule : tb_top
